// File: mpd_motor_pwm.sv
module mpd_motor_pwm
  import mpd_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES
)(
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         cyc_i,
  input  wire logic         stb_i,
  input  wire logic         we_i,
  input  wire logic [9:0]   adr_i,
  input  wire logic [3:0]   sel_i,
  input  wire logic [31:0]  dat_i,
  output logic      [31:0]  dat_o,
  output logic              ack_o,
  input  wire logic [15:0]  scaledDutyInput,
  input  wire logic         overCurrentPin,
  output logic              tickIrqReq,
  output logic              overflowPulse,
  output logic              compareReference,
  output mpd_gate_type      gates
);

  // ----------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------
  logic [7:0]  statusR,  statusNxt;
  logic [7:0]  ctrlR,    ctrlNxt;
  logic [11:0] dutyR,    dutyNxt;
  logic [11:0] periodR,  periodNxt;
  logic [7:0]  deadR,    deadNxt;
  logic [7:0]  chanR,    chanNxt;
  logic [7:0]  outR,     outNxt;
  logic [31:0] datR,     datNxt;
  logic        ackR;
  logic [11:0] cntR,     cntNxt;
  mpd_dir_type dirR,     dirNxt;
  logic        ovfR,     ovfNxt;
  logic        refR,     refNxt;
  logic [8:0]  dtCntR,   dtCntNxt;
  logic [31:0] cntAccR,  cntAccNxt;
  logic [31:0] dtAccR,   dtAccNxt;
  logic [31:0] tickCntR, tickCntNxt;
  logic [2:0]  ocSync;
  mpd_gate_type gatesNxt;

  logic        req, wr, cntTick, dtTick, tickPulse, ocFire, cmpHit;
  logic [7:0]  idx;
  logic [31:0] wmask, wdat;
  logic [11:0] cmpVal, topVal;
  logic [3:0]  rawPwm, sideLvl, finalLvl;
  mpd_cmp_mode_type mode;

  assign req  = cyc_i && stb_i && !ackR;
  assign wr   = req && we_i;
  assign idx  = adr_i[9:2];
  assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  assign mode = mpd_cmp_mode_type'(statusR[1:0]);

  // ----------------------------------------------------------------
  // rate enables
  // ----------------------------------------------------------------
  // fractional dividers give 12 MHz and 24 MHz average enable pulses
  always_comb
  begin
    cntTick   = (cntAccR + CNT_RATE_HZ) >= CLK_HZ;
    dtTick    = (dtAccR + DT_RATE_HZ) >= CLK_HZ;
    cntAccNxt = cntTick ? cntAccR + CNT_RATE_HZ - CLK_HZ
                        : cntAccR + CNT_RATE_HZ;
    dtAccNxt  = dtTick ? dtAccR + DT_RATE_HZ - CLK_HZ
                       : dtAccR + DT_RATE_HZ;
    tickPulse = (tickCntR == 32'(TICK_LEN - 1));
    tickCntNxt = tickPulse ? 32'h0000_0000 : tickCntR + 32'h0000_0001;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      cntAccR  <= 32'h0000_0000;
      dtAccR   <= 32'h0000_0000;
      tickCntR <= 32'h0000_0000;
    end
    else
    begin
      cntAccR  <= cntAccNxt;
      dtAccR   <= dtAccNxt;
      tickCntR <= tickCntNxt;
    end
  end

  // overcurrent pin synchroniser, acts once stages two and three are both high
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      ocSync <= 3'h0;
    else
      ocSync <= {ocSync[1:0], overCurrentPin};
  end
  assign ocFire = ocSync[2] && ocSync[1];

  // ----------------------------------------------------------------
  // counter and compare
  // ----------------------------------------------------------------
  // compare source: half the duty register in mode 11, else scaled upstream duty
  always_comb
  begin
    if (mode == CMP_BOTH)
      cmpVal = {1'b0, dutyR[11:1]};
    else
      cmpVal = {5'h00, scaledDutyInput[15:9]} + 12'(scaledDutyInput[8:5]
               >> 4) + {1'b0, scaledDutyInput[15:5]} - {5'h00,
               scaledDutyInput[15:9]};
    topVal = (periodR[11:1] == 11'h000) ? RST_WORD
                                        : {1'b0, periodR[11:1]} - 12'h001;
  end

  // centre-aligned up/down count with overflow at the top
  always_comb
  begin
    cntNxt = cntR;
    dirNxt = dirR;
    ovfNxt = 1'b0;
    if (ctrlR[CR_RUN] && cntTick)
    begin
      if (dirR == DIR_UP)
      begin
        if (cntR >= topVal)
        begin
          ovfNxt = 1'b1;
          dirNxt = DIR_DOWN;
          cntNxt = (cntR == RST_WORD) ? cntR : cntR - 12'h001;
        end
        else
          cntNxt = cntR + 12'h001;
      end
      else if (cntR == RST_WORD)
      begin
        dirNxt = DIR_UP;
        cntNxt = (topVal == RST_WORD) ? cntR : cntR + 12'h001;
      end
      else
        cntNxt = cntR - 12'h001;
    end
    if (wr && idx == IDX_COUNTER && ctrlR[CR_RUN])
      cntNxt = (dat_i[11:0] & wmask[11:0]) | (cntR & ~wmask[11:0]);
    refNxt = (cntR < cmpVal);
    cmpHit = cntTick && (cntR == cmpVal) &&
             ((dirR == DIR_UP && mode[0]) ||
              (dirR == DIR_DOWN && mode[1]));
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      cntR <= RST_WORD;
      dirR <= DIR_UP;
      ovfR <= 1'b0;
      refR <= 1'b0;
    end
    else
    begin
      cntR <= cntNxt;
      dirR <= dirNxt;
      ovfR <= ovfNxt;
      refR <= refNxt;
    end
  end

  // ----------------------------------------------------------------
  // deadtime
  // ----------------------------------------------------------------
  // a reference edge restarts the dead count when none is running; an edge that lands
  // inside an unfinished count releases the new side at once
  always_comb
  begin
    dtCntNxt = dtCntR;
    if (refNxt != refR)
    begin
      if (dtCntR != 9'h000 || deadR == RST_BYTE)
        dtCntNxt = 9'h000;
      else
        dtCntNxt = {1'b0, deadR} + 9'h001;
    end
    else if (dtTick && dtCntR != 9'h000)
      dtCntNxt = dtCntR - 9'h001;
    rawPwm[1] = refR && (dtCntR == 9'h000);          // low side
    rawPwm[0] = !refR && (dtCntR == 9'h000);         // high side
    rawPwm[3] = rawPwm[1];
    rawPwm[2] = rawPwm[0];
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      dtCntR <= 9'h000;
    else
      dtCntR <= dtCntNxt;
  end

  // ----------------------------------------------------------------
  // output stage, sides UH, UL, VH, VL
  // ----------------------------------------------------------------
  genvar s;
  generate
    for (s = 0; s < 4; s++)
    begin : gSide
      localparam bit HIGH = (s % 2 == 0);
      logic en, pol, moe, rev;
      assign en  = chanR[2*s];
      assign pol = chanR[2*s+1];
      assign moe = HIGH ? outR[OUT_MAIN_OUT_EN_HIGH] : outR[OUT_MAIN_OUT_EN_LOW];
      assign rev = HIGH ? ctrlR[CR_HREV] : ctrlR[CR_LREV];
      // enable/polarity select, then main enable or idle level
      assign sideLvl[s]  = en ? (rawPwm[s] ^ pol) : pol;
      assign finalLvl[s] = (moe ? sideLvl[s] : outR[IDLE_POS[s]])
                           ^ rev;
    end
  endgenerate

  // predriver: pmos gates get the inverted high side; off when disabled
  always_comb
  begin
    if (ctrlR[CR_PREDRV])
    begin
      gatesNxt.pmosGateU = !finalLvl[0];
      gatesNxt.pmosGateV = !finalLvl[2];
      gatesNxt.nmosGateU = finalLvl[1];
      gatesNxt.nmosGateV = finalLvl[3];
    end
    else
    begin
      gatesNxt.pmosGateU = 1'b1;
      gatesNxt.pmosGateV = 1'b1;
      gatesNxt.nmosGateU = 1'b0;
      gatesNxt.nmosGateV = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      gates <= '{1'b1, 1'b1, 1'b0, 1'b0};
    else
      gates <= gatesNxt;
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  // writes merge by byte lane; hardware sets beat software clears
  always_comb
  begin
    wdat      = dat_i & wmask;
    statusNxt = statusR;
    ctrlNxt   = ctrlR;
    dutyNxt   = dutyR;
    periodNxt = periodR;
    deadNxt   = deadR;
    chanNxt   = chanR;
    outNxt    = outR;
    if (wr && sel_i[0])
    begin
      if (idx == IDX_STATUS)
      begin
        statusNxt[ST_TICK_EN] = dat_i[ST_TICK_EN];
        statusNxt[1:0]        = dat_i[1:0];
        if (!dat_i[ST_TICK_FLAG])
          statusNxt[ST_TICK_FLAG] = 1'b0;
        if (!dat_i[ST_CMP_FLAG])
          statusNxt[ST_CMP_FLAG] = 1'b0;
      end
      else if (idx == IDX_CONTROL)
        ctrlNxt = dat_i[7:0] & CR_MASK;
      else if (idx == IDX_DEAD)
        deadNxt = dat_i[7:0];
      else if (idx == IDX_CHANCFG)
        chanNxt = dat_i[7:0];
      else if (idx == IDX_OUTIDLE)
        outNxt = dat_i[7:0] & OUT_MASK;
    end
    if (wr && idx == IDX_DUTY)
      dutyNxt = wdat[11:0] | (dutyR & ~wmask[11:0]);
    if (wr && idx == IDX_PERIOD)
      periodNxt = {wdat[11:1] | (periodR[11:1] & ~wmask[11:1]),
                   1'b0};
    if (tickPulse)
      statusNxt[ST_TICK_FLAG] = 1'b1;
    if (cmpHit)
      statusNxt[ST_CMP_FLAG] = 1'b1;
    if (ocFire)
    begin
      outNxt[OUT_MAIN_OUT_EN_HIGH] = 1'b0;
      outNxt[OUT_MAIN_OUT_EN_LOW] = 1'b0;
    end
    // read mux, unmapped words read zero
    if (idx == IDX_STATUS)
      datNxt = {24'h000000, statusR};
    else if (idx == IDX_CONTROL)
      datNxt = {24'h000000, ctrlR};
    else if (idx == IDX_DUTY)
      datNxt = {20'h00000, dutyR};
    else if (idx == IDX_PERIOD)
      datNxt = {20'h00000, periodR};
    else if (idx == IDX_COUNTER)
      datNxt = {20'h00000, cntR};
    else if (idx == IDX_DEAD)
      datNxt = {24'h000000, deadR};
    else if (idx == IDX_CHANCFG)
      datNxt = {24'h000000, chanR};
    else if (idx == IDX_OUTIDLE)
      datNxt = {24'h000000, outR};
    else
      datNxt = 32'h0000_0000;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      statusR <= RST_BYTE;
      ctrlR   <= RST_BYTE;
      dutyR   <= RST_WORD;
      periodR <= RST_WORD;
      deadR   <= RST_BYTE;
      chanR   <= RST_BYTE;
      outR    <= RST_BYTE;
      datR    <= 32'h0000_0000;
      ackR    <= 1'b0;
    end
    else
    begin
      statusR <= statusNxt;
      ctrlR   <= ctrlNxt;
      dutyR   <= dutyNxt;
      periodR <= periodNxt;
      deadR   <= deadNxt;
      chanR   <= chanNxt;
      outR    <= outNxt;
      datR    <= req ? datNxt : 32'h0000_0000;
      ackR    <= req;
    end
  end

  assign ack_o            = ackR;
  assign dat_o            = datR;
  assign tickIrqReq       = statusR[ST_TICK_FLAG] && statusR[ST_TICK_EN];
  assign overflowPulse    = ovfR;
  assign compareReference = refR;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  AST_PERIOD_LSB: assert property (periodR[0] == 1'b0)
    else $error("period bit zero not zero");
  AST_TICK_IRQ: assert property (tickPulse ##1 statusR[ST_TICK_EN]
    |-> tickIrqReq)
    else $error("tick irq not requested");
  AST_TICK_GATE: assert property (!statusR[ST_TICK_EN] |-> !tickIrqReq)
    else $error("tick irq without enable");
  AST_FLAG_CLEAR: assert property (wr && sel_i[0] && idx == IDX_STATUS &&
    !dat_i[ST_TICK_FLAG] && !tickPulse |=> !statusR[ST_TICK_FLAG])
    else $error("tick flag not cleared");
  AST_CMP_SET: assert property (cmpHit |=> statusR[ST_CMP_FLAG])
    else $error("compare flag not set");
  AST_CMP_NEVER: assert property (mode == CMP_NEVER && !statusR[ST_CMP_FLAG]
    |=> !statusR[ST_CMP_FLAG])
    else $error("compare flag set in mode 00");
  AST_CNT_UP: assert property (ctrlR[CR_RUN] && cntTick && dirR == DIR_UP &&
    cntR < topVal && !(wr && idx == IDX_COUNTER)
    |=> cntR == $past(cntR) + 12'h001)
    else $error("counter did not step up");
  AST_CNT_HOLD: assert property (!ctrlR[CR_RUN] |=> $stable(cntR))
    else $error("stopped counter moved");
  AST_PROTECT: assert property (ocFire |=> !outR[OUT_MAIN_OUT_EN_HIGH] && !outR[OUT_MAIN_OUT_EN_LOW])
    else $error("main enables not cleared");
  AST_PREDRV: assert property (ctrlR[CR_PREDRV]
    |=> gates.pmosGateU == !$past(finalLvl[0]))
    else $error("pmos gate not inverted");

  COV_OVERFLOW: cover property (ovfR);
  COV_CMP_DOWN: cover property (cmpHit && dirR == DIR_DOWN);
  COV_PROTECT:  cover property (ocFire && outR[OUT_MAIN_OUT_EN_HIGH]);

endmodule // mpd_motor_pwm

// File: mpd_pkg.sv
package mpd_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ       = 50_000_000;
  localparam int CNT_RATE_HZ  = 12_000_000;   // counter advance rate
  localparam int DT_UNIT_PS   = 41_670;       // one deadtime step
  localparam int DT_RATE_HZ   = int'(64'd1_000_000_000_000 / DT_UNIT_PS);
  localparam int TICK_US      = 1_000;        // periodic tick, 1 ms
  localparam int TICK_CYCLES  = CLK_HZ / 1_000_000 * TICK_US;

  // ----------------------------------------------------------------
  // register indexes (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_STATUS  = 8'hDF;
  localparam logic [7:0] IDX_CONTROL = 8'hE1;
  localparam logic [7:0] IDX_DUTY    = 8'hE2;
  localparam logic [7:0] IDX_PERIOD  = 8'hE4;
  localparam logic [7:0] IDX_COUNTER = 8'hE6;
  localparam logic [7:0] IDX_DEAD    = 8'hE9;
  localparam logic [7:0] IDX_CHANCFG = 8'hEA;
  localparam logic [7:0] IDX_OUTIDLE = 8'hF8;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int ST_TICK_FLAG = 7;
  localparam int ST_TICK_EN   = 6;
  localparam int ST_CMP_FLAG  = 4;
  localparam int CR_RUN       = 7;
  localparam int CR_BASE_ON   = 5;
  localparam int CR_HREV      = 4;
  localparam int CR_LREV      = 3;
  localparam int CR_PREDRV    = 0;
  localparam int OUT_MAIN_OUT_EN_HIGH     = 7;
  localparam int OUT_MAIN_OUT_EN_LOW     = 6;
  localparam logic [7:0] CR_MASK     = 8'hB9;
  localparam logic [7:0] OUT_MASK    = 8'hCF;
  // idle bit position per side, sides ordered UH, UL, VH, VL
  localparam int IDLE_POS [4] = '{1, 0, 3, 2};

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [11:0] RST_WORD = 12'h000;

  typedef enum logic [1:0] {
    CMP_NEVER = 2'b00,
    CMP_UP    = 2'b01,
    CMP_DOWN  = 2'b10,
    CMP_BOTH  = 2'b11
  } mpd_cmp_mode_type;

  typedef enum logic {
    DIR_UP   = 1'b0,
    DIR_DOWN = 1'b1
  } mpd_dir_type;

  typedef struct packed {
    logic pmosGateU;
    logic pmosGateV;
    logic nmosGateU;
    logic nmosGateV;
  } mpd_gate_type;

endpackage

// File: mpd_bridge_model.sv
// --------------------------------------------------------------
// bridge model: pmos/nmos legs with a bus current sense
// --------------------------------------------------------------
module mpd_bridge_model
  import mpd_pkg::*;
(
  input  wire logic         faultCmd,
  input  wire mpd_gate_type gates,
  output logic              overCurrentPin
);
  logic shortU;
  logic shortV;

  // pmos conducts on a low gate, nmos on a high gate
  assign shortU = !gates.pmosGateU && gates.nmosGateU;
  assign shortV = !gates.pmosGateV && gates.nmosGateV;

  // sense trips on a commanded fault or on a leg short
  assign overCurrentPin = faultCmd || shortU || shortV;
endmodule // mpd_bridge_model

// File: tb_top.sv
`define CHK(g, e) \
  begin \
    cmpCount++; \
    if ((g) !== (e)) \
    begin \
      mismatches++; \
      $display("[ERR] %0t got %0h exp %0h", $time, g, e); \
    end \
  end

module tb_top
  import mpd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 50;

  logic         clk, sys_rst, cyc, stb, we, ack, ovf, cref, irq, fault, ocp;
  logic [9:0]   adr;
  logic [3:0]   sel, v;
  logic [31:0]  wdat, rdat, q, c0;
  logic [15:0]  sduty;
  mpd_gate_type gates;
  logic [1:0]   g [2][4];
  logic [7:0]   idx [9] = '{IDX_STATUS, IDX_CONTROL, IDX_DUTY, IDX_PERIOD,
                            IDX_COUNTER, IDX_DEAD, IDX_CHANCFG, IDX_OUTIDLE,
                            8'h00};
  int           mismatches, cmpCount, cycCnt, n, k, e;
  time          t1, t2;

  mpd_motor_pwm #(.TICK_LEN(TICK)) dut (
    .clk(clk), .sys_rst(sys_rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .scaledDutyInput(sduty), .overCurrentPin(ocp), .tickIrqReq(irq),
    .overflowPulse(ovf), .compareReference(cref), .gates(gates));

  mpd_bridge_model bridge (.faultCmd(fault), .gates(gates),
    .overCurrentPin(ocp));

  // 50 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // --------------------------------------------------------------
  // bus and wait helpers
  // --------------------------------------------------------------
  task automatic wb(input logic w, input logic [7:0] i,
                    input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'b00};
    sel <= 4'hF;
    wdat <= d;
    // no own limit: only the hang guard ends a stalled wait
    do
    begin
      @(posedge clk);
    end
    while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    wb(1'b1, i, d);
  endtask

  task automatic rd(input logic [7:0] i);
    wb(1'b0, i, 32'h0);
  endtask

  task automatic wait_hi(ref logic s);
    int c;
    c = 0;
    do
    begin
      @(posedge clk);
      c++;
    end
    while (s !== 1'b1 && c < 3000);
    if (s !== 1'b1)
      mismatches++;
  endtask

  // cycles from a reference edge to the gate turning its side on
  task automatic dt_meas(input logic lvl, output int cnt);
    int c;
    c = 0;
    while (cref !== ~lvl && c < 3000)
    begin
      @(posedge clk);
      c++;
    end
    while (cref !== lvl && c < 3000)
    begin
      @(posedge clk);
      c++;
    end
    cnt = 0;
    while ((lvl ? gates.nmosGateU : !gates.pmosGateU) !== 1'b1 && cnt < 600)
    begin
      @(posedge clk);
      cnt++;
    end
  endtask

  task automatic finish_test;
    if (mismatches == 0 && cmpCount > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // hang guard
  always @(posedge clk)
  begin
    cycCnt++;
    if (cycCnt == 40000)
    begin
      mismatches++;
      finish_test();
    end
  end

  // --------------------------------------------------------------
  // test sequence
  // --------------------------------------------------------------
  initial
  begin
    {cyc, stb, we, fault, sys_rst} = 5'b00001;
    adr = '0;
    sel = '0;
    wdat = '0;
    sduty = '0;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    `CHK(gates, 4'b1100);
    foreach (idx[i])
    begin
      rd(idx[i]);
      `CHK(q, 32'h0);
    end
    wr(IDX_CONTROL, 32'hFF);
    rd(IDX_CONTROL);
    `CHK(q, {24'h0, CR_MASK});
    wr(IDX_PERIOD, 32'hFFFF);
    rd(IDX_PERIOD);
    `CHK(q, 32'hFFE);
    wr(IDX_DUTY, 32'hFFFF);
    rd(IDX_DUTY);
    `CHK(q, 32'hFFF);
    wr(8'h00, 32'hFF);
    rd(8'h00);
    `CHK(q, 32'h0);
    // counter: write refused while stopped, then 500 clocks of running
    wr(IDX_CONTROL, 32'h0);
    rd(IDX_COUNTER);
    c0 = q;
    wr(IDX_COUNTER, 32'h123);
    rd(IDX_COUNTER);
    `CHK(q, c0);
    wr(IDX_CONTROL, 32'h80);
    wr(IDX_COUNTER, 32'h100);
    repeat (497) @(posedge clk);
    wr(IDX_CONTROL, 32'h0);
    rd(IDX_COUNTER);
    c0 = q;
    `CHK((q >= 32'h177) && (q <= 32'h179), 1'b1);
    repeat (20) @(posedge clk);
    rd(IDX_COUNTER);
    `CHK(q, c0);
    // periodic tick and write-zero-to-clear flag
    // clear a stale flag twice so t1 marks a fresh tick
    wr(IDX_STATUS, 32'h40);
    wait_hi(irq);
    wr(IDX_STATUS, 32'h40);
    wait_hi(irq);
    t1 = $time;
    wr(IDX_STATUS, 32'hC0);
    rd(IDX_STATUS);
    `CHK(q[7], 1'b1);
    wr(IDX_STATUS, 32'h40);
    rd(IDX_STATUS);
    `CHK(q[7], 1'b0);
    wait_hi(irq);
    t2 = $time;
    `CHK(int'((t2 - t1) / 20), TICK);
    wr(IDX_STATUS, 32'h0);
    repeat (TICK + 10) @(posedge clk);
    `CHK(irq, 1'b0);
    rd(IDX_STATUS);
    `CHK(q[7], 1'b1);
    // centre-aligned count, top = 0x10/2-1 = 7
    wr(IDX_PERIOD, 32'h10);
    wr(IDX_CONTROL, 32'h81);
    wr(IDX_COUNTER, 32'h0);
    wait_hi(ovf);
    rd(IDX_COUNTER);
    `CHK((q >= 32'h6) && (q <= 32'h7), 1'b1);
    wait_hi(ovf);
    t1 = $time;
    wait_hi(ovf);
    t2 = $time;
    n = int'((t2 - t1) / 20);
    `CHK((n >= 56) && (n <= 61), 1'b1);
    // compare modes, compare value 4: down pass, then up pass
    for (int m = 0; m < 4; m++)
    begin
      sduty <= (m == 3) ? 16'hFFFF : 16'h0080;
      wr(IDX_DUTY, (m == 3) ? 32'h8 : 32'hFFE);
      wait_hi(ovf);
      wr(IDX_STATUS, m);
      repeat (18) @(posedge clk);
      rd(IDX_STATUS);
      `CHK(q[4], m[1]);
      wr(IDX_STATUS, m);
      wait_hi(ovf);
      rd(IDX_STATUS);
      `CHK(q[4], m[0]);
    end
    // idle levels through the predriver
    wr(IDX_STATUS, 32'h0);
    repeat (3) @(posedge clk);
    `CHK(gates, 4'b1100);
    for (int i = 15; i >= 0; i--)
    begin
      v = i[3:0];
      wr(IDX_OUTIDLE, {28'h0, v});
      repeat (3) @(posedge clk);
      `CHK(gates, {~v[1], ~v[3], v[0], v[2]});
    end
    repeat (6) @(posedge clk);
    // enable/polarity on high sides with a steady reference
    wr(IDX_DEAD, 32'h0);
    wr(IDX_OUTIDLE, 32'hC0);
    for (int r = 0; r < 2; r++)
    begin
      sduty <= r[0] ? 16'hFFFF : 16'h0000;
      repeat (80) @(posedge clk);
      `CHK(cref, r[0]);
      for (int c = 0; c < 4; c++)
      begin
        wr(IDX_CHANCFG, {26'h0, c[1:0], 2'b00, c[1:0]});
        repeat (4) @(posedge clk);
        g[r][c] = gates[3:2];
      end
      `CHK(g[r][0], 2'b11);
      `CHK(g[r][2], 2'b00);
      `CHK(g[r][3], ~g[r][1]);
    end
    `CHK(g[0][1] !== g[1][1], 1'b1);
    wr(IDX_CHANCFG, 32'h11);
    wr(IDX_CONTROL, 32'h91);
    repeat (4) @(posedge clk);
    `CHK(gates[3:2], ~g[1][1]);
    wr(IDX_CONTROL, 32'h81);
    // deadtime 0 and 11, high side then low side
    wr(IDX_PERIOD, 32'h100);
    sduty <= 16'h0800;
    for (int j = 0; j < 4; j++)
    begin
      e = j[1] ? (12 * 4167) / 2000 : 0;
      wr(IDX_DEAD, j[1] ? 32'd11 : 32'd0);
      wr(IDX_CHANCFG, j[0] ? 32'h04 : 32'h01);
      dt_meas(j[0], n);
      `CHK((n >= e - 2) && (n <= e + 3), 1'b1);
    end
    // deadtime longer than the short high reference pulse
    wr(IDX_DEAD, 32'hFF);
    sduty <= 16'h0200;
    wr(IDX_CHANCFG, 32'h05);
    wait_hi(ovf);
    n = 0;
    k = 0;
    repeat (1100)
    begin
      @(posedge clk);
      if (gates.nmosGateU === 1'b1)
        n++;
      if (gates.pmosGateU === 1'b0)
        k++;
    end
    `CHK(n, 0);
    `CHK(k > 0, 1'b1);
    // overcurrent clears both main enables and wins over a set
    wr(IDX_CHANCFG, 32'h22);
    wr(IDX_OUTIDLE, 32'hC0);
    fault <= 1'b1;
    repeat (8) @(posedge clk);
    rd(IDX_OUTIDLE);
    `CHK(q, 32'h0);
    `CHK(gates, 4'b1100);
    wr(IDX_OUTIDLE, 32'hC0);
    rd(IDX_OUTIDLE);
    `CHK(q, 32'h0);
    fault <= 1'b0;
    repeat (6) @(posedge clk);
    wr(IDX_OUTIDLE, 32'hC0);
    rd(IDX_OUTIDLE);
    `CHK(q, 32'hC0);
    finish_test();
  end
endmodule // tb_top
